// *** eag_pkg.sv ***
// Constants, kinds and carrier types for the effective address generator.
package eag_pkg;
	localparam int ADDR_W = 32;
	// Mode selector codes of the operand locator.
	localparam logic [2:0] MODE_DATA_DIRECT = 3'h0;
	localparam logic [2:0] MODE_ADDR_DIRECT = 3'h1;
	localparam logic [2:0] MODE_INDIRECT = 3'h2;
	localparam logic [2:0] MODE_POSTINC = 3'h3;
	localparam logic [2:0] MODE_PREDEC = 3'h4;
	localparam logic [2:0] MODE_DISP = 3'h5;
	localparam logic [2:0] MODE_INDEX = 3'h6;
	localparam logic [2:0] MODE_SPECIAL = 3'h7;
	// Register selector codes while the mode selector is all ones.
	localparam logic [2:0] SPEC_ABS_SHORT = 3'h0;
	localparam logic [2:0] SPEC_ABS_LONG = 3'h1;
	localparam logic [2:0] SPEC_PC_DISP = 3'h2;
	localparam logic [2:0] SPEC_PC_INDEX = 3'h3;
	localparam logic [2:0] SPEC_IMMEDIATE = 3'h4;
	// Operand sizes and the address steps that belong to them.
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;
	localparam logic [31:0] STEP_BYTE = 32'h00000001;
	localparam logic [31:0] STEP_WORD = 32'h00000002;
	localparam logic [31:0] STEP_LONG = 32'h00000004;
	localparam logic [2:0] STACK_REG = 3'h7;
	// Implied register selections.
	localparam logic [1:0] IMPL_STATUS = 2'h0;
	localparam logic [1:0] IMPL_USER_SP = 2'h1;
	localparam logic [1:0] IMPL_ACTIVE_SP = 2'h2;
	localparam logic [1:0] IMPL_PC = 2'h3;
	localparam logic [2:0] MAX_WORDS = 3'h5;
	// Register map and fields.
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_COUNT = 12'h008;
	localparam logic [11:0] OFF_LAST_ADDR = 12'h00C;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;
	localparam logic CTRL_ENABLE_RESET = 1'h1;
	localparam int STAT_ILLEGAL_BIT = 0;
	localparam int STAT_PROG_BIT = 1;
	localparam int STAT_KIND_LSB = 8;
	// Operand kinds, one-hot.
	typedef enum logic [5:0] {
		KIND_DATA_REG = 6'h01,
		KIND_ADDR_REG = 6'h02,
		KIND_MEMORY = 6'h04,
		KIND_IMMEDIATE = 6'h08,
		KIND_IMPLIED = 6'h10,
		KIND_ILLEGAL = 6'h20
	} eag_kind_type;
	// Decode request from instruction fetch.
	typedef struct packed {
		logic [15:0] opWord;
		logic [3:0][15:0] extWords;
		logic [1:0] size;
		logic jumpClass;
		logic implied;
		logic [1:0] impliedSel;
		logic [31:0] pc;
	} eag_req_type;
	// Register values returned by the register file for the selects.
	typedef struct packed {
		logic [31:0] addrVal;
		logic [31:0] idxVal;
		logic [15:0] statusWord;
		logic [31:0] userStackPtr;
		logic [31:0] activeStackPtr;
	} eag_regval_type;
	// Decode result.
	typedef struct packed {
		eag_kind_type kind;
		logic [3:0] regNum;
		logic [31:0] addr;
		logic [31:0] immData;
		logic memRef;
		logic progRef;
		logic [2:0] instrWords;
		logic wbEn;
		logic [2:0] wbNum;
		logic [31:0] wbVal;
	} eag_res_type;
endpackage

// *** eag_core.sv ***
// Effective address generator with its control and status registers on APB.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// RULE1 - Instruction is one to five words
// RULE2 - Following words are immediates or extensions
// RULE3 - Locator is mode and register fields
// RULE4 - Register number from field, kind from mode
// RULE5 - Register direct operand needs no memory
// RULE6 - Data direct uses selected data register
// RULE7 - Address direct uses selected address register
// RULE8 - Tag each reference program or data
// RULE9 - Indirect forms data, jumps program; postincrement and predecrement jumps are tagged data here
// RULE10 - Postincrement adds one, two or four
// RULE11 - Stack byte postincrement adds two
// RULE12 - Predecrement subtracts first, then addresses
// RULE13 - Stack byte predecrement subtracts two
// RULE14 - Displacement adds sign-extended extension word
// RULE15 - Index adds register and short offset
// RULE16 - Absolute short one word, long two
// RULE17 - PC relative with offset or index
// RULE18 - Implied selects fixed special registers
// RULE19 - All-ones mode uses register field
// RULE20 - Absolute short is sign-extended
module eag_core (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reqValid,
	output logic reqReady,
	input wire eag_pkg::eag_req_type req,
	output logic [2:0] addrRegSel,
	output logic [3:0] indexRegSel,
	input wire eag_pkg::eag_regval_type regVal,
	output logic resValid,
	output eag_pkg::eag_res_type res
);
	logic ctrlEnable_r;
	logic illegalSeen_r;
	logic [31:0] decodeCount_r;
	logic [31:0] lastAddr_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic resValid_r;
	eag_pkg::eag_res_type res_r;
	eag_pkg::eag_res_type res_nxt;
	logic [2:0] mode;
	logic [2:0] regField;
	logic [15:0] ext0;
	logic [15:0] ext1;
	logic [31:0] step;
	logic [31:0] wideOffset;
	logic [31:0] shortOffset;
	logic [31:0] indexVal;
	logic [2:0] extCount;
	logic taken;
	logic apbSetup;
	logic apbWrite;
	logic mapped;
	logic [31:0] readValue;

	// The decoder takes requests only while software has it enabled.
	assign reqReady = ctrlEnable_r;
	assign taken = reqValid & ctrlEnable_r;

	// Field split of the operation word and first extension words.
	assign mode = req.opWord[5:3]; // [RULE3]
	assign regField = req.opWord[2:0]; // [RULE3]
	assign ext0 = req.extWords[0];
	assign ext1 = req.extWords[1];

	// Register file selects; bit 3 of the index select marks an address register.
	assign addrRegSel = regField; // [RULE4]
	assign indexRegSel = {ext0[15], ext0[14:12]}; // [RULE4]

	// Step size; a byte step on the stack register is widened to keep it even.
	always_comb begin
		case (req.size)
			eag_pkg::SIZE_BYTE: begin
				step = eag_pkg::STEP_BYTE; // [RULE10] [RULE12]
			end
			eag_pkg::SIZE_LONG: begin
				step = eag_pkg::STEP_LONG;
			end
			default: begin
				step = eag_pkg::STEP_WORD;
			end
		endcase
		if (req.size == eag_pkg::SIZE_BYTE && regField == eag_pkg::STACK_REG) begin
			step = eag_pkg::STEP_WORD; // [RULE11] [RULE13]
		end
	end

	// Sign-extended offsets and the index value, word or long as bit 11 asks.
	assign wideOffset = {{16{ext0[15]}}, ext0}; // [RULE14] [RULE20]
	assign shortOffset = {{24{ext0[7]}}, ext0[7:0]}; // [RULE15]
	assign indexVal = ext0[11] ? regVal.idxVal
		: {{16{regVal.idxVal[15]}}, regVal.idxVal[15:0]};

	// Decode of the operand locator into a result.
	always_comb begin
		res_nxt = '0;
		res_nxt.kind = eag_pkg::KIND_ILLEGAL;
		res_nxt.wbNum = regField;
		extCount = 3'h0;
		if (req.implied) begin
			res_nxt.kind = eag_pkg::KIND_IMPLIED; // [RULE18]
			case (req.impliedSel)
				eag_pkg::IMPL_STATUS: begin
					res_nxt.addr = {16'h0000, regVal.statusWord};
				end
				eag_pkg::IMPL_USER_SP: begin
					res_nxt.addr = regVal.userStackPtr;
				end
				eag_pkg::IMPL_ACTIVE_SP: begin
					res_nxt.addr = regVal.activeStackPtr;
				end
				default: begin
					res_nxt.addr = req.pc;
				end
			endcase
		end else begin
			case (mode)
				eag_pkg::MODE_DATA_DIRECT: begin
					res_nxt.kind = eag_pkg::KIND_DATA_REG; // [RULE5] [RULE6]
					res_nxt.regNum = {1'h0, regField};
				end
				eag_pkg::MODE_ADDR_DIRECT: begin
					res_nxt.kind = eag_pkg::KIND_ADDR_REG; // [RULE5] [RULE7]
					res_nxt.regNum = {1'h1, regField};
				end
				eag_pkg::MODE_INDIRECT: begin
					res_nxt.kind = eag_pkg::KIND_MEMORY;
					res_nxt.addr = regVal.addrVal;
				end
				eag_pkg::MODE_POSTINC: begin
					res_nxt.kind = eag_pkg::KIND_MEMORY;
					res_nxt.addr = regVal.addrVal; // [RULE10]
					res_nxt.wbEn = 1'h1;
					res_nxt.wbVal = regVal.addrVal + step; // [RULE10]
				end
				eag_pkg::MODE_PREDEC: begin
					res_nxt.kind = eag_pkg::KIND_MEMORY;
					res_nxt.wbEn = 1'h1;
					res_nxt.wbVal = regVal.addrVal - step; // [RULE12]
					res_nxt.addr = regVal.addrVal - step; // [RULE12]
				end
				eag_pkg::MODE_DISP: begin
					res_nxt.kind = eag_pkg::KIND_MEMORY;
					res_nxt.addr = regVal.addrVal + wideOffset; // [RULE14]
					extCount = 3'h1; // [RULE14]
				end
				eag_pkg::MODE_INDEX: begin
					res_nxt.kind = eag_pkg::KIND_MEMORY;
					res_nxt.addr = regVal.addrVal + indexVal + shortOffset; // [RULE15]
					extCount = 3'h1; // [RULE15]
				end
				eag_pkg::MODE_SPECIAL: begin
					// The register field picks the special form here.
					case (regField) // [RULE19]
						eag_pkg::SPEC_ABS_SHORT: begin
							res_nxt.kind = eag_pkg::KIND_MEMORY;
							res_nxt.addr = wideOffset; // [RULE16] [RULE20]
							extCount = 3'h1;
						end
						eag_pkg::SPEC_ABS_LONG: begin
							res_nxt.kind = eag_pkg::KIND_MEMORY;
							res_nxt.addr = {ext0, ext1}; // [RULE16]
							extCount = 3'h2;
						end
						eag_pkg::SPEC_PC_DISP: begin
							res_nxt.kind = eag_pkg::KIND_MEMORY;
							res_nxt.addr = req.pc + wideOffset; // [RULE17]
							extCount = 3'h1;
						end
						eag_pkg::SPEC_PC_INDEX: begin
							res_nxt.kind = eag_pkg::KIND_MEMORY;
							res_nxt.addr = req.pc + indexVal + shortOffset; // [RULE17]
							extCount = 3'h1;
						end
						eag_pkg::SPEC_IMMEDIATE: begin
							res_nxt.kind = eag_pkg::KIND_IMMEDIATE; // [RULE2]
							case (req.size)
								eag_pkg::SIZE_BYTE: begin
									res_nxt.immData = {24'h000000, ext0[7:0]};
									extCount = 3'h1;
								end
								eag_pkg::SIZE_LONG: begin
									res_nxt.immData = {ext0, ext1};
									extCount = 3'h2;
								end
								default: begin
									res_nxt.immData = {16'h0000, ext0};
									extCount = 3'h1;
								end
							endcase
						end
						default: begin
							res_nxt.kind = eag_pkg::KIND_ILLEGAL;
						end
					endcase
				end
				default: begin
					res_nxt.kind = eag_pkg::KIND_ILLEGAL;
				end
			endcase
		end
		// Memory references are tagged; PC forms, and jumps other than postincrement or predecrement, fetch from program space.
		res_nxt.memRef = (res_nxt.kind == eag_pkg::KIND_MEMORY); // [RULE8]
		if (res_nxt.memRef) begin
			if (mode == eag_pkg::MODE_SPECIAL
				&& (regField == eag_pkg::SPEC_PC_DISP
				|| regField == eag_pkg::SPEC_PC_INDEX)) begin
				res_nxt.progRef = 1'h1; // [RULE8]
			end else if (mode == eag_pkg::MODE_POSTINC
				|| mode == eag_pkg::MODE_PREDEC) begin
				res_nxt.progRef = 1'h0; // [RULE9]
			end else begin
				res_nxt.progRef = req.jumpClass; // [RULE9]
			end
		end
		// Total words: the operation word plus the extensions it asks for.
		res_nxt.instrWords = 3'h1 + extCount; // [RULE1] [RULE2]
		if (res_nxt.instrWords > eag_pkg::MAX_WORDS) begin
			res_nxt.instrWords = eag_pkg::MAX_WORDS; // [RULE1]
		end
	end

	// Result register and its one-cycle valid.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			resValid_r <= 1'h0;
			res_r <= '0;
		end else begin
			resValid_r <= taken;
			if (taken) begin
				res_r <= res_nxt;
			end
		end
	end

	assign resValid = resValid_r;
	assign res = res_r;

	// APB decode; a setup cycle prepares the answer so the access needs no wait.
	assign apbSetup = psel & ~penable;
	assign apbWrite = psel & penable & pwrite;
	assign mapped = (paddr == eag_pkg::OFF_CTRL) || (paddr == eag_pkg::OFF_STATUS)
		|| (paddr == eag_pkg::OFF_COUNT) || (paddr == eag_pkg::OFF_LAST_ADDR);

	// Read multiplexer; unmapped addresses read zero.
	always_comb begin
		readValue = 32'h00000000;
		case (paddr)
			eag_pkg::OFF_CTRL: begin
				readValue[eag_pkg::CTRL_ENABLE_BIT] = ctrlEnable_r;
			end
			eag_pkg::OFF_STATUS: begin
				readValue[eag_pkg::STAT_ILLEGAL_BIT] = illegalSeen_r;
				readValue[eag_pkg::STAT_PROG_BIT] = res_r.progRef;
				readValue[eag_pkg::STAT_KIND_LSB +: 6] = res_r.kind;
			end
			eag_pkg::OFF_COUNT: begin
				readValue = decodeCount_r;
			end
			eag_pkg::OFF_LAST_ADDR: begin
				readValue = lastAddr_r;
			end
			default: begin
				readValue = 32'h00000000;
			end
		endcase
	end

	// Read data and error answer, captured in the setup cycle.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'h0;
		end else if (apbSetup) begin
			prdata_r <= pwrite ? 32'h00000000 : readValue;
			pslverr_r <= ~mapped;
		end
	end

	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign pready = 1'h1;

	// Control register: enable bit.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrlEnable_r <= eag_pkg::CTRL_ENABLE_RESET;
		end else if (apbWrite && paddr == eag_pkg::OFF_CTRL) begin
			ctrlEnable_r <= pwdata[eag_pkg::CTRL_ENABLE_BIT];
		end
	end

	// Sticky illegal flag; write one clears it, a new illegal decode wins.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			illegalSeen_r <= 1'h0;
		end else if (taken && res_nxt.kind == eag_pkg::KIND_ILLEGAL) begin
			illegalSeen_r <= 1'h1;
		end else if (apbWrite && paddr == eag_pkg::OFF_STATUS
			&& pwdata[eag_pkg::STAT_ILLEGAL_BIT]) begin
			illegalSeen_r <= 1'h0;
		end
	end

	// Decode counter; a clear through control restarts it, a decode adds on top.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			decodeCount_r <= 32'h00000000;
		end else if (apbWrite && paddr == eag_pkg::OFF_CTRL
			&& pwdata[eag_pkg::CTRL_CLEAR_BIT]) begin
			decodeCount_r <= taken ? 32'h00000001 : 32'h00000000;
		end else if (taken) begin
			decodeCount_r <= decodeCount_r + 32'h00000001;
		end
	end

	// Last memory address computed, kept for software inspection.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			lastAddr_r <= 32'h00000000;
		end else if (taken && res_nxt.memRef) begin
			lastAddr_r <= res_nxt.addr;
		end
	end
endmodule

// *** eag_core_assertions.sv ***
// Checker of the effective address generator decode ports.
`timescale 1ns/1ps
module eag_core_assertions (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic reqValid,
	input wire logic reqReady,
	input wire eag_pkg::eag_req_type req,
	input wire eag_pkg::eag_regval_type regVal,
	input wire logic resValid,
	input wire eag_pkg::eag_res_type res
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic tk;
	logic [2:0] md;
	logic [2:0] rf;
	logic [31:0] dSum;
	logic [31:0] sx;
	// Locator fields and sums of a taken request.
	assign tk = reqValid && reqReady && !req.implied;
	assign md = req.opWord[5:3];
	assign rf = req.opWord[2:0];
	assign sx = {{16{req.extWords[0][15]}}, req.extWords[0]};
	assign dSum = regVal.addrVal + sx;
	a_result_one_cycle: assert property (reqValid && reqReady |=> resValid)
		else $error("result pulse missing");
	a_idle_no_result: assert property (!(reqValid && reqReady) |=> !resValid)
		else $error("result without request");
	a_data_direct: assert property (tk && md == 3'h0 |=> !res.memRef && res.regNum == {1'b0, $past(rf)})
		else $error("data direct wrong");
	a_addr_direct: assert property (tk && md == 3'h1 |=> res.regNum == {1'b1, $past(rf)})
		else $error("address direct wrong");
	a_postinc_addr: assert property (tk && md == 3'h3 |=> res.wbEn && res.addr == $past(regVal.addrVal))
		else $error("postincrement address wrong");
	a_predec_first: assert property (tk && md == 3'h4 |=> res.wbEn && res.addr == res.wbVal)
		else $error("predecrement address wrong");
	a_disp_sum: assert property (tk && md == 3'h5 |=> res.addr == $past(dSum) && res.instrWords == 3'h2)
		else $error("displacement sum wrong");
	a_abs_short_sext: assert property (tk && md == 3'h7 && rf == 3'h0 |=> res.addr == $past(sx))
		else $error("absolute short wrong");
	a_pc_program: assert property (tk && md == 3'h7 && rf inside {3'h2, 3'h3} |=> res.progRef)
		else $error("pc reference not program");
	a_indirect_data: assert property (tk && md == 3'h2 && !req.jumpClass |=> !res.progRef)
		else $error("indirect reference not data");
	// Main scenarios reached.
	cover property (tk && md == 3'h3);
	cover property (tk && md == 3'h7 && rf == 3'h4);
	cover property (reqValid && !reqReady);
endmodule
bind eag_core eag_core_assertions u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .reqValid(reqValid),
	.reqReady(reqReady), .req(req), .regVal(regVal), .resValid(resValid), .res(res));

// *** eag_regfile_model.sv ***
// Register file model that answers the generator's register selects.
`timescale 1ns/1ps
module eag_regfile_model (
	input wire logic [2:0] addrRegSel,
	input wire logic [3:0] indexRegSel,
	output eag_pkg::eag_regval_type regVal
);
	logic [31:0] aReg [8];
	logic [31:0] dReg [8];
	// Contents are loaded by the bench; selects are answered in the same cycle.
	always_comb begin
		regVal.addrVal = aReg[addrRegSel];
		regVal.idxVal = indexRegSel[3] ? aReg[indexRegSel[2:0]] : dReg[indexRegSel[2:0]];
		regVal.statusWord = 16'h2700;
		regVal.userStackPtr = dReg[0];
		regVal.activeStackPtr = aReg[7];
	end
endmodule

// *** tb_eag_core.sv ***
// Self-checking bench of the effective address generator.
`timescale 1ns/1ps
module tb_eag_core;
	logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic reqValid = 0, reqReady, resValid;
	logic [2:0] addrRegSel;
	logic [3:0] indexRegSel;
	eag_pkg::eag_req_type req = '0, r;
	eag_pkg::eag_regval_type regVal;
	eag_pkg::eag_res_type res, x;
	eag_pkg::eag_res_type q[$];
	int n_fail = 0, n_compared = 0, cyc = 0;
	eag_core dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .reqValid(reqValid), .reqReady(reqReady), .req(req),
		.addrRegSel(addrRegSel), .indexRegSel(indexRegSel), .regVal(regVal),
		.resValid(resValid), .res(res));
	eag_regfile_model m (.addrRegSel(addrRegSel), .indexRegSel(indexRegSel), .regVal(regVal));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task test_done;
		if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task cmp_dec(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task cmp_apb(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	// One APB transfer; read data and error are taken at the access edge.
	task apb(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] ex, logic err);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		if (!w) cmp_apb("prdata", ex, prdata);
		cmp_apb("pslverr", 32'(err), 32'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Expected result worked out from the addressing rules.
	function automatic eag_pkg::eag_res_type expect_of(eag_pkg::eag_req_type t);
		eag_pkg::eag_res_type e;
		logic [15:0] x0;
		logic [2:0] rf;
		logic [31:0] a, ix, st, sx;
		x0 = t.extWords[0];
		rf = t.opWord[2:0];
		a = m.aReg[rf];
		sx = {{16{x0[15]}}, x0};
		ix = x0[15] ? m.aReg[x0[14:12]] : m.dReg[x0[14:12]];
		if (!x0[11]) ix = {{16{ix[15]}}, ix[15:0]};
		ix = ix + {{24{x0[7]}}, x0[7:0]};
		st = t.size == 2'h2 ? 32'h4 : (t.size == 2'h0 && rf != 3'h7) ? 32'h1 : 32'h2;
		e = '0;
		e.kind = eag_pkg::KIND_MEMORY;
		e.memRef = 1'b1;
		e.progRef = t.jumpClass;
		e.instrWords = 3'h2;
		e.wbNum = rf;
		case (t.opWord[5:3])
			3'h0: e.kind = eag_pkg::KIND_DATA_REG;
			3'h1: e.kind = eag_pkg::KIND_ADDR_REG;
			3'h2: {e.addr, e.instrWords} = {a, 3'h1};
			3'h3: {e.addr, e.wbVal, e.wbEn, e.instrWords} = {a, a + st, 1'b1, 3'h1};
			3'h4: {e.addr, e.wbVal, e.wbEn, e.instrWords} = {a - st, a - st, 1'b1, 3'h1};
			3'h5: e.addr = a + sx;
			3'h6: e.addr = a + ix;
			default: case (rf)
				3'h0: e.addr = sx;
				3'h1: {e.addr, e.instrWords} = {x0, t.extWords[1], 3'h3};
				3'h2: {e.addr, e.progRef} = {t.pc + sx, 1'b1};
				3'h3: {e.addr, e.progRef} = {t.pc + ix, 1'b1};
				3'h4: begin
					e.kind = eag_pkg::KIND_IMMEDIATE;
					e.instrWords = t.size == 2'h2 ? 3'h3 : 3'h2;
					e.immData = t.size == 2'h2 ? {x0, t.extWords[1]} : t.size == 2'h0 ?
						{24'h0, x0[7:0]} : {16'h0, x0};
				end
				default: e.kind = eag_pkg::KIND_ILLEGAL;
			endcase
		endcase
		if (e.kind != eag_pkg::KIND_MEMORY) e.memRef = 1'b0;
		if (e.wbEn) e.progRef = 1'b0;
		if (e.kind inside {eag_pkg::KIND_DATA_REG, eag_pkg::KIND_ADDR_REG})
			e.regNum = {e.kind == eag_pkg::KIND_ADDR_REG, rf};
		if (t.implied) begin
			e.kind = eag_pkg::KIND_IMPLIED;
			case (t.impliedSel)
				2'h0: e.addr = 32'h00002700;
				2'h1: e.addr = m.dReg[0];
				2'h2: e.addr = m.aReg[7];
				default: e.addr = t.pc;
			endcase
		end
		return e;
	endfunction
	task dec(eag_pkg::eag_req_type t);
		reqValid <= 1'b1;
		req <= t;
		@(posedge clk_sys);
		q.push_back(expect_of(t));
	endtask
	// Result watcher: takes the oldest note whenever a result appears.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_fail++;
			test_done;
		end
		if (resValid === 1'b1) begin
			x = q.size() > 0 ? q.pop_front() : '1;
			cmp_dec("kind", 32'(x.kind), 32'(res.kind));
			cmp_dec("memRef", 32'(x.memRef), 32'(res.memRef));
			if (x.kind == eag_pkg::KIND_MEMORY) begin
				cmp_dec("addr", x.addr, res.addr);
				cmp_dec("progRef", 32'(x.progRef), 32'(res.progRef));
				cmp_dec("words", 32'(x.instrWords), 32'(res.instrWords));
			end
			if (x.regNum != 4'h0) cmp_dec("regNum", 32'(x.regNum), 32'(res.regNum));
			if (x.kind == eag_pkg::KIND_IMMEDIATE) cmp_dec("imm", x.immData, res.immData);
			if (x.kind == eag_pkg::KIND_IMPLIED) cmp_dec("implied", x.addr, res.addr);
			if (x.wbEn) cmp_dec("wbVal", x.wbVal, res.wbVal);
		end
	end
	initial begin
		void'($urandom(32'h9BB6));
		for (int i = 0; i < 8; i++) {m.aReg[i], m.dReg[i]} = {$urandom, $urandom};
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		apb(1'b0, eag_pkg::OFF_CTRL, '0, 32'h1, 1'b0);
		apb(1'b0, 12'h010, '0, 32'h0, 1'b1);
		for (int i = 0; i < 256; i++) begin
			r = '0;
			r.opWord = {10'($urandom), 3'(i % 8), i % 8 == 7 ? 3'(i / 8) : 3'($urandom)};
			r.extWords = {$urandom, $urandom};
			{r.size, r.jumpClass, r.pc} = {2'($urandom % 3), 1'($urandom), $urandom};
			dec(r);
			if ($urandom % 4 == 0) begin
				reqValid <= 1'b0;
				@(posedge clk_sys);
			end
		end
		for (int k = 0; k < 4; k++) dec('{implied: 1'b1, impliedSel: 2'(k), default: '0});
		reqValid <= 1'b0;
		apb(1'b0, eag_pkg::OFF_STATUS, '0, 32'h00001001, 1'b0);
		apb(1'b1, eag_pkg::OFF_CTRL, 32'h0, '0, 1'b0);
		reqValid <= 1'b1;
		@(posedge clk_sys);
		cmp_dec("reqReady", 32'h0, 32'(reqReady));
		reqValid <= 1'b0;
		apb(1'b1, eag_pkg::OFF_CTRL, 32'h3, '0, 1'b0);
		apb(1'b0, eag_pkg::OFF_COUNT, '0, 32'h0, 1'b0);
		cmp_dec("pending", 32'h0, 32'(q.size()));
		test_done;
	end
endmodule
